// ==== verilog/bbr_cfg.svh ====
`ifndef BBR_CFG_SVH
`define BBR_CFG_SVH
// ****************************************
// timing figures and field layout
// ****************************************
`define BBR_CLK_NS 50
`define BBR_AS_FLOAT_NS 30
`define BBR_STROBE_HIGH_NS 40
// cycles the other lines float before as* is let go; as* is never driven high on release
`define BBR_AS_FLOAT_CYC ((`BBR_AS_FLOAT_NS / `BBR_CLK_NS) < 1 ? 1 : (`BBR_AS_FLOAT_NS / `BBR_CLK_NS))
// strobes high at least this many cycles (strictly more than 40 ns, rounded up)
`define BBR_STROBE_HIGH_CYC ((`BBR_STROBE_HIGH_NS / `BBR_CLK_NS) + 1)
`define BBR_ADDR_W 31
`define BBR_AM_W 6
`define BBR_BYTE_W 8
`define BBR_SETUP_CYC 1
`define BBR_CNT_W 4
`define BBR_CNT_ONE 4'h1
`define BBR_CNT_ZERO 4'h0
`endif

// ==== verilog/bbr_pkg.sv ====
`default_nettype none
package bbr_pkg;
  // ****************************************
  // types
  // ****************************************
  typedef logic [30:0] bbr_addr_t;
  typedef logic [5:0] bbr_am_t;
  typedef logic [7:0] bbr_byte_t;
  typedef enum logic [3:0]
  {
    BBR_M_IDLE = 4'b0000,
    BBR_M_WAIT_FREE = 4'b0001,
    BBR_M_QUIET = 4'b0010,
    BBR_M_ADDR = 4'b0011,
    BBR_M_ASLOW = 4'b0100,
    BBR_M_WAIT_ACK_FREE = 4'b0101,
    BBR_M_STROBE = 4'b0110,
    BBR_M_END = 4'b0111,
    BBR_M_AS_HIGH = 4'b1000,
    BBR_M_REL = 4'b1001
  } bbr_mst_state_t;
  typedef enum logic [2:0]
  {
    BBR_S_IDLE = 3'b000,
    BBR_S_DECODE = 3'b001,
    BBR_S_FETCH = 3'b010,
    BBR_S_ACK = 3'b011,
    BBR_S_ERR = 3'b100,
    BBR_S_RELDATA = 3'b101,
    BBR_S_WAIT_AS = 3'b110
  } bbr_slv_state_t;
endpackage
`default_nettype wire

// ==== verilog/bbr_bus_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// backplane lines; every driven line is out and in under an active-low output enable, one ctl_oe_n shared by the control lines
interface bbr_bus_if;
  import bbr_pkg::*;
  // address group, master driven
  logic [30:0] addr_o;
  logic addr_oe_n;
  logic [30:0] addr_i;
  logic [5:0] am_o;
  logic [5:0] am_i;
  logic iack_n_o;
  logic iack_n_i;
  logic lword_n_o;
  logic lword_n_i;
  logic write_n_o;
  logic write_n_i;
  // strobes, master driven
  logic as_n_o;
  logic as_n_oe_n;
  logic as_n_i;
  logic ds0_n_o;
  logic ds0_n_i;
  logic ds1_n_o;
  logic ds1_n_i;
  logic ctl_oe_n;
  // slave answer
  logic dtack_n_o;
  logic dtack_n_oe_n;
  logic dtack_n_i;
  logic berr_n_o;
  logic berr_n_oe_n;
  logic berr_n_i;
  logic [7:0] data_o;
  logic data_oe_n;
  logic [7:0] data_i;
  modport master (
    output addr_o, addr_oe_n, am_o, iack_n_o, lword_n_o, write_n_o,
    output as_n_o, as_n_oe_n, ds0_n_o, ds1_n_o, ctl_oe_n,
    input addr_i, as_n_i, dtack_n_i, berr_n_i, data_i
  );
  modport slave (
    input addr_i, am_i, iack_n_i, lword_n_i, write_n_i, as_n_i, ds0_n_i, ds1_n_i,
    output dtack_n_o, dtack_n_oe_n, berr_n_o, berr_n_oe_n, data_o, data_oe_n
  );
endinterface
`default_nettype wire

// ==== verilog/bbr_master.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bbr_cfg.svh"
// Behaviour
// - report done only after as low
// - requester drops busy on early done
// - drive only after address free, as high
// - float all but as, then as high
// - as driven high floats within 30 ns
// - strobes stay high over 40 ns
// - may drive once as seen high
// - address, modifier, iack and lword high
// - as low after address setup
// - slave compares address on as fall
// - strobes never lead as at master
// - one answer acknowledges both strobes
// - write high before ds0 falls
// - dtack and berr high before strobe
// - ds0 alone reads odd byte on d0-7
// - slave answers only after strobe falls
// - dtack after data valid, held
// - on answer, raise strobes at once (here ds0 at once, as a cycle later, or at release on the last cycle)
// - slave latches data at dtack (here the master latches at dtack, the slave a cycle before)
// - slave floats data before dtack release
// - release address, raise ds0, as, float
module bbr_master
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bus side
  bbr_bus_if.master bus,
  // user side: grant from requester, read request and result
  input wire logic granted,
  input wire logic req_valid,
  input wire bbr_pkg::bbr_addr_t req_addr,
  input wire bbr_pkg::bbr_am_t req_am,
  input wire logic req_last,
  output logic busy,
  output logic done_early,
  output logic rsp_valid,
  output logic rsp_err,
  output bbr_pkg::bbr_byte_t rsp_data
);
  import bbr_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [2:0] as_sy;
  logic [2:0] dtack_sy;
  logic [2:0] berr_sy;
  logic [2:0] abus_sy;
  logic as_hi_reg;
  logic dtack_lo_reg;
  logic berr_lo_reg;
  logic abus_free_reg;

  // three stages; level changes once stages two and three agree; address free when all high
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      as_sy <= 3'h7;
      dtack_sy <= 3'h7;
      berr_sy <= 3'h7;
      abus_sy <= 3'h7;
    end
    else
    begin
      as_sy <= {as_sy[1:0], bus.as_n_i};
      dtack_sy <= {dtack_sy[1:0], bus.dtack_n_i};
      berr_sy <= {berr_sy[1:0], bus.berr_n_i};
      abus_sy <= {abus_sy[1:0], &bus.addr_i};
    end
  end

  // filtered levels
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      as_hi_reg <= 1'b1;
      dtack_lo_reg <= 1'b0;
      berr_lo_reg <= 1'b0;
      abus_free_reg <= 1'b1;
    end
    else
    begin
      if (as_sy[1] == as_sy[2]) as_hi_reg <= as_sy[2];
      if (dtack_sy[1] == dtack_sy[2]) dtack_lo_reg <= ~dtack_sy[2];
      if (berr_sy[1] == berr_sy[2]) berr_lo_reg <= ~berr_sy[2];
      if (abus_sy[1] == abus_sy[2]) abus_free_reg <= abus_sy[2];
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  bbr_mst_state_t state_reg;
  logic [`BBR_CNT_W-1:0] cnt_reg;
  logic last_reg;
  logic cnt_done;
  assign cnt_done = (cnt_reg == `BBR_CNT_ZERO);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= BBR_M_IDLE;
      cnt_reg <= `BBR_CNT_ZERO;
      last_reg <= 1'b0;
    end
    else
    begin
      if (!cnt_done) cnt_reg <= cnt_reg - `BBR_CNT_ONE;
      case (state_reg)
        BBR_M_IDLE:
          if (granted && req_valid)
          begin
            last_reg <= req_last;
            state_reg <= busy ? BBR_M_ADDR : BBR_M_WAIT_FREE;
          end
        // previous owner must have let go of address lines and as
        BBR_M_WAIT_FREE:
          if (as_hi_reg && abus_free_reg)
          begin
            state_reg <= BBR_M_QUIET;
            cnt_reg <= `BBR_CNT_W'(`BBR_STROBE_HIGH_CYC);
          end
        // strobes driven high long enough before first assertion
        BBR_M_QUIET:
          if (cnt_done)
          begin
            state_reg <= BBR_M_ADDR;
            cnt_reg <= `BBR_CNT_W'(`BBR_SETUP_CYC);
          end
        BBR_M_ADDR:
          if (cnt_done) state_reg <= BBR_M_ASLOW;
        BBR_M_ASLOW:
          state_reg <= BBR_M_WAIT_ACK_FREE;
        BBR_M_WAIT_ACK_FREE:
          if (!dtack_lo_reg && !berr_lo_reg) state_reg <= BBR_M_STROBE;
        BBR_M_STROBE:
          if (dtack_lo_reg || berr_lo_reg) state_reg <= BBR_M_END;
        // give up the bus after the final cycle or once grant is lost, else stay owner
        BBR_M_END:
          if (last_reg || !granted)
          begin
            state_reg <= BBR_M_AS_HIGH;
            cnt_reg <= `BBR_CNT_W'(`BBR_AS_FLOAT_CYC);
          end
          else
          begin
            state_reg <= BBR_M_IDLE;
          end
        BBR_M_AS_HIGH:
          if (cnt_done) state_reg <= BBR_M_REL;
        BBR_M_REL:
          state_reg <= BBR_M_IDLE;
        default:
          state_reg <= BBR_M_IDLE;
      endcase
    end
  end

  // ****************************************
  // bus drive
  // ****************************************
  logic [30:0] addr_reg;
  logic [5:0] am_reg;
  logic addr_oe_n_reg;
  logic ctl_oe_n_reg;
  logic as_oe_n_reg;
  logic as_n_reg;
  logic ds0_n_reg;

  // address, modifier and drivers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_reg <= '0;
      am_reg <= '0;
      addr_oe_n_reg <= 1'b1;
      ctl_oe_n_reg <= 1'b1;
      as_oe_n_reg <= 1'b1;
    end
    else if (state_reg == BBR_M_IDLE && granted && req_valid)
    begin
      addr_reg <= req_addr;
      am_reg <= req_am;
      if (busy) addr_oe_n_reg <= 1'b0;
    end
    else if (state_reg == BBR_M_WAIT_FREE && as_hi_reg && abus_free_reg)
    begin
      addr_oe_n_reg <= 1'b0;
      ctl_oe_n_reg <= 1'b0;
      as_oe_n_reg <= 1'b0;
    end
    else if (state_reg == BBR_M_END)
    begin
      addr_oe_n_reg <= 1'b1;
      if (last_reg || !granted) ctl_oe_n_reg <= 1'b1;
    end
    else if (state_reg == BBR_M_REL)
    begin
      as_oe_n_reg <= 1'b1;
    end
  end

  // strobes: ds0 after as low; on release as floats to its pull-up, as 30 ns is under a clock
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      as_n_reg <= 1'b1;
      ds0_n_reg <= 1'b1;
    end
    else
    begin
      if (state_reg == BBR_M_ASLOW) as_n_reg <= 1'b0;
      else if (state_reg == BBR_M_END && !last_reg && granted) as_n_reg <= 1'b1;
      else if (state_reg == BBR_M_REL) as_n_reg <= 1'b1;
      if (state_reg == BBR_M_WAIT_ACK_FREE && !dtack_lo_reg && !berr_lo_reg)
        ds0_n_reg <= 1'b0;
      else if (state_reg == BBR_M_STROBE && (dtack_lo_reg || berr_lo_reg))
        ds0_n_reg <= 1'b1;
    end
  end

  // ****************************************
  // user side
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      done_early <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= '0;
    end
    else
    begin
      // ownership held from first drive until as released
      if (state_reg == BBR_M_WAIT_FREE && as_hi_reg && abus_free_reg) busy <= 1'b1;
      else if (state_reg == BBR_M_REL) busy <= 1'b0;
      // early done pulse lets the requester drop bus busy during the last cycle
      done_early <= (state_reg == BBR_M_WAIT_ACK_FREE) && last_reg && (as_n_reg == 1'b0);
      rsp_valid <= (state_reg == BBR_M_STROBE) && (dtack_lo_reg || berr_lo_reg);
      if (state_reg == BBR_M_STROBE && (dtack_lo_reg || berr_lo_reg))
      begin
        rsp_err <= berr_lo_reg;
        rsp_data <= bus.data_i;
      end
    end
  end

  // fixed read-cycle fields; ds1 never asserted for an odd byte
  assign bus.addr_o = addr_reg;
  assign bus.addr_oe_n = addr_oe_n_reg;
  assign bus.am_o = am_reg;
  assign bus.iack_n_o = 1'b1;
  assign bus.lword_n_o = 1'b1;
  assign bus.write_n_o = 1'b1;
  assign bus.as_n_o = as_n_reg;
  assign bus.as_n_oe_n = as_oe_n_reg;
  assign bus.ds0_n_o = ds0_n_reg;
  assign bus.ds1_n_o = 1'b1;
  assign bus.ctl_oe_n = ctl_oe_n_reg;
endmodule // bbr_master
`default_nettype wire

// ==== verilog/bbr_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bbr_cfg.svh"
// addressed byte-read responder
module bbr_slave
#(
  parameter bbr_pkg::bbr_addr_t BASE = 31'h0000_0000,
  parameter bbr_pkg::bbr_addr_t MASK = 31'h7FFF_FF00,
  parameter bbr_pkg::bbr_am_t AM_OK = 6'h3D
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bus side
  bbr_bus_if.slave bus,
  // user side: local memory port
  output bbr_pkg::bbr_addr_t mem_addr,
  output logic mem_rd,
  input wire bbr_pkg::bbr_byte_t mem_data,
  input wire logic mem_err,
  output logic selected
);
  import bbr_pkg::*;

  // ****************************************
  // synchronisers
  // ****************************************
  logic [2:0] as_sy;
  logic [2:0] ds0_sy;
  logic [2:0] ds1_sy;
  logic as_lo_reg;
  logic ds_lo_reg;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      as_sy <= 3'h7;
      ds0_sy <= 3'h7;
      ds1_sy <= 3'h7;
    end
    else
    begin
      as_sy <= {as_sy[1:0], bus.as_n_i};
      ds0_sy <= {ds0_sy[1:0], bus.ds0_n_i};
      ds1_sy <= {ds1_sy[1:0], bus.ds1_n_i};
    end
  end

  // strobe leading as by skew is tolerated: both are only read as levels
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      as_lo_reg <= 1'b0;
      ds_lo_reg <= 1'b0;
    end
    else
    begin
      if (as_sy[1] == as_sy[2]) as_lo_reg <= ~as_sy[2];
      if (ds0_sy[1] == ds0_sy[2] && ds1_sy[1] == ds1_sy[2])
        ds_lo_reg <= ~(ds0_sy[2] & ds1_sy[2]);
    end
  end

  // ****************************************
  // responder
  // ****************************************
  bbr_slv_state_t state_reg;
  logic err_reg;
  logic hit;
  logic illegal;
  // address lines are stable by the time as is seen after sync
  assign hit = ((bus.addr_i & MASK) == (BASE & MASK)) && (bus.am_i == AM_OK)
    && bus.iack_n_i;
  // only odd-byte reads are served here
  assign illegal = !bus.lword_n_i || !bus.write_n_i || !bus.ds1_n_i;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= BBR_S_IDLE;
      selected <= 1'b0;
      err_reg <= 1'b0;
      mem_addr <= '0;
    end
    else
    begin
      case (state_reg)
        BBR_S_IDLE:
          if (as_lo_reg)
          begin
            selected <= hit;
            mem_addr <= bus.addr_i;
            state_reg <= hit ? BBR_S_DECODE : BBR_S_WAIT_AS;
          end
        // wait for a strobe before any answer
        BBR_S_DECODE:
          if (ds_lo_reg)
          begin
            err_reg <= illegal;
            state_reg <= illegal ? BBR_S_ERR : BBR_S_FETCH;
          end
          else if (!as_lo_reg)
          begin
            selected <= 1'b0;
            state_reg <= BBR_S_IDLE;
          end
        BBR_S_FETCH:
          state_reg <= mem_err ? BBR_S_ERR : BBR_S_ACK;
        BBR_S_ACK, BBR_S_ERR:
          if (!ds_lo_reg) state_reg <= BBR_S_RELDATA;
        BBR_S_RELDATA:
          state_reg <= BBR_S_WAIT_AS;
        // one answer per as; next cycle needs as back high
        BBR_S_WAIT_AS:
          if (!as_lo_reg)
          begin
            selected <= 1'b0;
            err_reg <= 1'b0;
            state_reg <= BBR_S_IDLE;
          end
        default:
          state_reg <= BBR_S_IDLE;
      endcase
    end
  end

  // ****************************************
  // bus drive
  // ****************************************
  logic [7:0] data_reg;
  logic data_oe_n_reg;
  logic dtack_n_reg;
  logic berr_n_reg;

  // data latched one cycle before dtack, held until strobe rises
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      data_reg <= '0;
      data_oe_n_reg <= 1'b1;
      dtack_n_reg <= 1'b1;
      berr_n_reg <= 1'b1;
      mem_rd <= 1'b0;
    end
    else
    begin
      mem_rd <= (state_reg == BBR_S_DECODE) && ds_lo_reg && !illegal;
      if (state_reg == BBR_S_FETCH && !mem_err)
      begin
        data_reg <= mem_data;
        data_oe_n_reg <= 1'b0;
      end
      else if (state_reg == BBR_S_ACK && !ds_lo_reg)
      begin
        data_oe_n_reg <= 1'b1;
      end
      // data already driven the cycle before dtack falls
      if (state_reg == BBR_S_ACK && ds_lo_reg && !data_oe_n_reg) dtack_n_reg <= 1'b0;
      else if (state_reg == BBR_S_RELDATA) dtack_n_reg <= 1'b1;
      if (state_reg == BBR_S_ERR && ds_lo_reg) berr_n_reg <= 1'b0;
      else if (state_reg == BBR_S_RELDATA) berr_n_reg <= 1'b1;
    end
  end

  // open-collector style answers: enable only while pulling low
  assign bus.data_o = data_reg;
  assign bus.data_oe_n = data_oe_n_reg;
  assign bus.dtack_n_o = dtack_n_reg;
  assign bus.dtack_n_oe_n = dtack_n_reg;
  assign bus.berr_n_o = berr_n_reg;
  assign bus.berr_n_oe_n = berr_n_reg;
endmodule // bbr_slave
`default_nettype wire

// ==== tb/bbr_bus_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module bbr_bus_checker
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // master side
  input wire logic [30:0] addr_o,
  input wire logic addr_oe_n,
  input wire logic as_n_o,
  input wire logic as_n_oe_n,
  input wire logic ds0_n_o,
  input wire logic ctl_oe_n,
  // resolved lines
  input wire logic [30:0] addr_i,
  input wire logic as_n_i,
  input wire logic ds0_n_i,
  input wire logic iack_n_i,
  input wire logic lword_n_i,
  input wire logic write_n_i,
  input wire logic dtack_n_i,
  input wire logic berr_n_i,
  // slave side
  input wire logic [7:0] data_o,
  input wire logic data_oe_n
);
  // ****************************************
  // handover and byte read checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  chk_take_when_free: assert property ($fell(addr_oe_n) |->
    $past(addr_i) == 31'h7fff_ffff && $past(as_n_i))
    else $error("drivers enabled on a busy bus");
  chk_float_before_as: assert property ($rose(as_n_oe_n) |->
    $past(addr_oe_n) && $past(ctl_oe_n) && as_n_o)
    else $error("address strobe floated before other lines");
  chk_as_float_quick: assert property (!(addr_oe_n && ctl_oe_n && !as_n_oe_n && as_n_o))
    else $error("address strobe driven high too long");
  chk_strobe_quiet: assert property (($fell(as_n_i) || $fell(ds0_n_i)) |->
    $past(as_n_i, 2) || !as_n_i && $past(ds0_n_i, 2))
    else $error("strobe not high long enough");
  chk_addr_setup: assert property ($fell(as_n_i) |-> !addr_oe_n && $past(!addr_oe_n)
    && $stable(addr_o) && iack_n_i && lword_n_i)
    else $error("address strobe before address valid");
  chk_as_leads_ds: assert property ((!ctl_oe_n && !ds0_n_o) |-> !as_n_oe_n && !as_n_o)
    else $error("data strobe low without address strobe");
  chk_one_answer: assert property (!(!dtack_n_i && !berr_n_i))
    else $error("both answers low");
  chk_ds_when_free: assert property ($fell(ds0_n_i) |->
    $past(dtack_n_i) && $past(berr_n_i) && $past(write_n_i))
    else $error("data strobe while bus not free");
  chk_answer_after_ds: assert property (($fell(dtack_n_i) || $fell(berr_n_i)) |->
    !ds0_n_i && $past(!ds0_n_i))
    else $error("answer before data strobe");
  chk_data_held: assert property ((!dtack_n_i && !ds0_n_i) |-> !data_oe_n)
    else $error("data not driven under acknowledge");
  chk_data_stable: assert property ((!dtack_n_i && $past(!dtack_n_i) && !data_oe_n)
    |-> $stable(data_o))
    else $error("read data moved under acknowledge");
  chk_end_prompt: assert property (($fell(dtack_n_i) || $fell(berr_n_i)) |->
    ##[1:8] ds0_n_i)
    else $error("data strobe not raised after answer");
  chk_release_order: assert property ($rose(dtack_n_i) |-> data_oe_n && $past(data_oe_n))
    else $error("acknowledge released before data");
  chk_release_prompt: assert property ($rose(ds0_n_i) |-> ##[1:8] (dtack_n_i && berr_n_i))
    else $error("answer not released after strobe");
endmodule // bbr_bus_checker
`default_nettype wire

// ==== tb/backplane_byte_read_and_master_handover_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module backplane_byte_read_and_master_handover_tb;
  import bbr_pkg::*;
  // ****************************************
  // stimulus, wires and design
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic granted = 1'b0;
  logic req_valid = 1'b0;
  logic req_last = 1'b0;
  logic mem_err = 1'b0;
  logic err_sel = 1'b0;
  bbr_addr_t req_addr = 31'h0000_0000;
  bbr_am_t req_am = 6'h3d;
  bbr_byte_t mem_data = 8'h00;
  logic busy, done_early, rsp_valid, rsp_err, mem_rd, selected;
  bbr_byte_t rsp_data;
  bbr_addr_t mem_addr;
  logic [8:0] exp_q[$];
  logic [8:0] exp_w;
  logic [31:0] r;
  logic dtack_q = 1'b1;
  logic ds0_q = 1'b1;
  int failures = 0;
  int checked = 0;
  int seed = 32'h0000_71be;
  always #25 sys_clk = ~sys_clk;
  bbr_bus_if bus();
  // every released line floats to its pull-up
  assign bus.addr_i = bus.addr_oe_n ? 31'h7fff_ffff : bus.addr_o;
  assign bus.am_i = bus.ctl_oe_n ? 6'h3f : bus.am_o;
  assign bus.iack_n_i = bus.ctl_oe_n | bus.iack_n_o;
  assign bus.lword_n_i = bus.ctl_oe_n | bus.lword_n_o;
  assign bus.write_n_i = bus.ctl_oe_n | bus.write_n_o;
  assign bus.ds0_n_i = bus.ctl_oe_n | bus.ds0_n_o;
  assign bus.ds1_n_i = bus.ctl_oe_n | bus.ds1_n_o;
  assign bus.as_n_i = bus.as_n_oe_n | bus.as_n_o;
  assign bus.dtack_n_i = bus.dtack_n_oe_n | bus.dtack_n_o;
  assign bus.berr_n_i = bus.berr_n_oe_n | bus.berr_n_o;
  assign bus.data_i = bus.data_oe_n ? 8'hff : bus.data_o;
  bbr_master bbr_master_i (.sys_clk(sys_clk), .rst(rst), .bus(bus), .granted(granted),
    .req_valid(req_valid), .req_addr(req_addr), .req_am(req_am), .req_last(req_last),
    .busy(busy), .done_early(done_early), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_data(rsp_data));
  bbr_slave bbr_slave_i (.sys_clk(sys_clk), .rst(rst), .bus(bus), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_data(mem_data), .mem_err(mem_err), .selected(selected));
  bbr_bus_checker bbr_bus_checker_i (.sys_clk(sys_clk), .rst(rst), .addr_o(bus.addr_o),
    .addr_oe_n(bus.addr_oe_n), .as_n_o(bus.as_n_o), .as_n_oe_n(bus.as_n_oe_n),
    .ds0_n_o(bus.ds0_n_o), .ctl_oe_n(bus.ctl_oe_n), .addr_i(bus.addr_i),
    .as_n_i(bus.as_n_i), .ds0_n_i(bus.ds0_n_i), .iack_n_i(bus.iack_n_i),
    .lword_n_i(bus.lword_n_i), .write_n_i(bus.write_n_i), .dtack_n_i(bus.dtack_n_i),
    .berr_n_i(bus.berr_n_i), .data_o(bus.data_o), .data_oe_n(bus.data_oe_n));
  // local memory: one cycle latency, data derived from the address
  always @(posedge sys_clk)
  begin
    #1;
    mem_data <= mem_addr[7:0] ^ 8'ha5;
    mem_err <= err_sel;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [8:0] got, input logic [8:0] want);
    checked++;
    if (got !== want)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one request; a hit notes its answer, a miss notes nothing
  task automatic rd(input bbr_addr_t a, input logic e, input logic l, input logic hit);
    int k;
    @(posedge sys_clk);
    #1;
    granted = 1'b1;
    req_addr = a;
    req_last = l;
    err_sel = e;
    req_valid = 1'b1;
    if (hit)
      exp_q.push_back(e ? 9'h100 : {1'b0, a[7:0] ^ 8'ha5});
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    for (k = 0; k < 200 && exp_q.size() != 0; k++)
      @(posedge sys_clk);
    if (exp_q.size() != 0)
    begin
      failures++;
      close_out();
    end
    repeat (10) @(posedge sys_clk);
    if (hit) chk({8'h00, busy}, {8'h00, !l});
  endtask
  // ****************************************
  // monitor and main sequence
  // ****************************************
  // answers are popped in order; an unexpected answer meets an impossible note
  always @(posedge sys_clk)
  begin
    dtack_q <= bus.dtack_n_i;
    ds0_q <= bus.ds0_n_i;
    if (bus.dtack_n_i === 1'b0 && dtack_q === 1'b1 && exp_q.size() > 0)
      chk({1'b0, bus.data_i}, {1'b0, exp_q[0][7:0]});
    if (bus.ds0_n_i === 1'b0 && ds0_q === 1'b1)
      chk({7'h00, bus.ds1_n_i, bus.write_n_i}, 9'h003);
    if (done_early === 1'b1)
    begin
      chk({6'h00, busy, bus.as_n_i, bus.as_n_oe_n}, 9'h004);
      granted <= 1'b0;
    end
    if (mem_rd === 1'b1)
      chk({7'h00, selected, bus.ds0_n_i}, 9'h002);
    if (rsp_valid === 1'b1)
    begin
      exp_w = exp_q.size() > 0 ? exp_q.pop_front() : 9'h1ff;
      chk({rsp_err, rsp_err ? 8'h00 : rsp_data}, exp_w);
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    for (int n = 0; n < 16; n++)
    begin
      r = $random(seed);
      rd({23'h00_0000, r[7:0]}, (r[9] & r[8]) | (n == 3), r[10] | (n == 15), 1'b1);
    end
    // miss: no answer ever comes, so recover by a mid-run reset
    rd(31'h0000_0100, 1'b0, 1'b1, 1'b0);
    repeat (40) @(posedge sys_clk);
    chk({6'h00, selected, bus.dtack_n_i, bus.berr_n_i}, 9'h003);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    r = $random(seed);
    rd({23'h00_0000, r[7:0]}, 1'b0, 1'b1, 1'b1);
    close_out();
  end
endmodule // backplane_byte_read_and_master_handover_tb
`default_nettype wire
